// ### tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import timer16_pkg::*;
  // ****
  // Bench signals
  // ****
  logic clk_in, nrst_in, pin, prv;
  reg_req_t req;
  logic [31:0] rdata_out, d;
  logic [15:0] count_out, c0;
  logic wrap_out, filter_tick_out;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  timer16_clock_edge_reload u_timer16_clock_edge_reload (.clk_in(clk_in), .nrst_in(nrst_in),
    .req_in(req), .timer_input_pin_in(pin), .prev_wrap_in(prv), .rdata_out(rdata_out),
    .count_out(count_out), .wrap_out(wrap_out), .filter_tick_out(filter_tick_out));
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  // Hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ****
  // Bus and compare tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk_in);
    req.wr <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_in);
    req.rd <= 1'b0;
    @(negedge clk_in);
    d = rdata_out;
    @(posedge clk_in);
  endtask
  task automatic wait_wrap;
    int i;
    i = 0;
    do begin
      @(negedge clk_in);
      i++;
    end while (wrap_out !== 1'b1 && i < 40);
    chk({31'h0, wrap_out}, 32'h1);
    @(posedge clk_in);
  endtask
  task automatic pulse;
    prv <= 1'b1;
    @(posedge clk_in);
    prv <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic pins(input logic v);
    pin <= v;
    repeat (4) @(posedge clk_in);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    rd(8'h08);
    chk(d, 32'hffff);
    wr(8'h04, 32'hffffffff);
    rd(8'h04);
    chk(d, 32'hfef);
    wr(8'h08, 32'hffff1234);
    rd(8'h08);
    chk(d, 32'h1234);
    wr(8'h14, 32'hffffffff);
    rd(8'h14);
    chk(d, 32'h0);
    $display("Test registers done");
  endtask
  task automatic t_timer;
    wr(8'h08, 32'hfff0);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h81);
    wait_wrap();
    wr(8'h08, 32'hfffa);
    wait_wrap();
    rd(8'h0c);
    chk({31'h0, d[15:0] >= 16'hfffa}, 32'h1);
    wr(8'h00, 32'h0);
    $display("Test timer done");
  endtask
  task automatic t_shot;
    wr(8'h08, 32'hfff8);
    for (int e = 0; e < 4; e++) begin
      pins(e != 1);
      wr(8'h04, {25'h0, 2'(e), 5'h0});
      wr(8'h00, 32'h09);
      if (e != 3) begin
        rd(8'h0c);
        c0 = d[15:0];
        rd(8'h0c);
        chk(d, {16'h0, c0});
        pin <= !pin;
      end
      wait_wrap();
      rd(8'h00);
      chk({31'h0, d[0]}, 32'h0);
    end
    wr(8'h00, 32'h01);
    wait_wrap();
    wr(8'h00, 32'h0);
    rd(8'h0c);
    chk({31'h0, d[15:0] < 16'h0008}, 32'h1);
    $display("Test one-shot done");
  endtask
  task automatic t_presc;
    logic [3:0] s;
    int f;
    for (int i = 0; i < 4; i++) begin
      s = (i == 3) ? 4'h8 : 4'(i);
      wr(8'h04, {20'h0, s, 4'h0, s});
      // Let ticks of the old selection drain
      @(posedge clk_in);
      f = 0;
      repeat (64) begin
        @(negedge clk_in);
        f += filter_tick_out;
      end
      @(posedge clk_in);
      chk(f, s[3] ? 0 : 64 >> s);
      rd(8'h0c);
      c0 = d[15:0];
      wr(8'h00, 32'h01);
      repeat (62) @(posedge clk_in);
      wr(8'h00, 32'h0);
      rd(8'h0c);
      chk({16'h0, d[15:0] - c0}, s[3] ? 0 : 64 >> s);
    end
    $display("Test prescaler done");
  endtask
  task automatic t_event;
    wr(8'h08, 32'hffff);
    for (int e = 0; e < 4; e++) begin
      wr(8'h04, {24'h0, 1'b1, 2'(e), 5'h0});
      wr(8'h00, 32'h15);
      rd(8'h0c);
      c0 = d[15:0];
      pins(1'b1);
      pins(1'b0);
      wr(8'h00, 32'h0);
      rd(8'h0c);
      chk({16'h0, d[15:0] - c0}, (e == 3) ? 0 : (e == 2) ? 2 : 1);
    end
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h05);
    repeat (3) pulse();
    wr(8'h00, 32'h0);
    rd(8'h0c);
    chk({16'h0, c0 - d[15:0]}, 32'h3);
    wr(8'h08, {16'h0, d[15:0] + 16'h2});
    wr(8'h00, 32'h15);
    repeat (3) pulse();
    rd(8'h0c);
    chk(d, 32'h0);
    $display("Test event done");
  endtask
  // Measured value counts ticks after the opening edge
  task automatic t_measure;
    wr(8'h04, 32'h20);
    wr(8'h00, 32'h0d);
    repeat (2) begin
      pins(1'b1);
      pins(1'b0);
    end
    rd(8'h10);
    chk(d, 32'h7);
    wr(8'h04, 32'h40);
    pins(1'b1);
    pins(1'b0);
    rd(8'h10);
    chk(d, 32'h3);
    wr(8'h00, 32'h0);
    $display("Test measurement done");
  endtask
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    nrst_in = 1'b0;
    pin = 1'b0;
    prv = 1'b0;
    req = '0;
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    t_regs();
    t_timer();
    t_shot();
    t_presc();
    t_event();
    t_measure();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### tb/timer16_clock_edge_reload_chk.sv
`default_nettype none
module timer16_clock_edge_reload_chk
  import timer16_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire reg_req_t req_in,
  input wire logic timer_input_pin_in,
  input wire logic prev_wrap_in,
  input wire logic [31:0] rdata_out,
  input wire logic [15:0] count_out,
  input wire logic wrap_out,
  input wire logic filter_tick_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // ****
  // Register shadows
  // ****
  logic [7:0] ctl_reg; // Main control copy
  logic [11:0] cfg_reg; // Clock and edge copy, reserved bit cleared
  logic [15:0] lim_reg; // Limit copy
  logic [1:0] run_reg; // Cycles of steady full-rate timer mode
  wire run_now = ctl_reg[3:0] == 4'h1 && cfg_reg[3:0] == 4'h0 && !req_in.wr;
  wire fsl = cfg_reg[11:8] != 4'h0;
  // Track writes as the design should take them
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ctl_reg <= 8'h00;
      cfg_reg <= 12'h000;
      lim_reg <= 16'hffff;
      run_reg <= 2'h0;
    end else begin
      if (req_in.wr && req_in.addr == 8'h00) ctl_reg <= req_in.wdata[7:0];
      if (req_in.wr && req_in.addr == 8'h04) cfg_reg <= req_in.wdata[11:0] & 12'hfef;
      if (req_in.wr && req_in.addr == 8'h08) lim_reg <= req_in.wdata[15:0];
      run_reg <= !run_now ? 2'h0 : (run_reg == 2'h3 ? run_reg : run_reg + 2'h1);
    end
  end
  idle_read_a: assert property (
    (!req_in.rd || req_in.addr > 8'h10) |=> rdata_out == 32'h0)
    else $error("read data not zero");
  lim_read_a: assert property (
    req_in.rd && req_in.addr == 8'h08 |=> rdata_out == {16'h0, lim_reg})
    else $error("limit readback wrong");
  cfg_read_a: assert property (
    req_in.rd && req_in.addr == 8'h04 |=> rdata_out == {20'h0, cfg_reg})
    else $error("clock edge readback wrong");
  tick_space_a: assert property (
    filter_tick_out && fsl && $past(fsl) && $past(fsl, 2) |=> !filter_tick_out)
    else $error("filter ticks too close");
  tick_stop_a: assert property (
    cfg_reg[11] && $past(cfg_reg[11]) && $past(cfg_reg[11], 2) |-> !filter_tick_out)
    else $error("filter tick while stopped");
  timer_step_a: assert property (
    run_reg == 2'h3 && $past(count_out) != 16'hffff |->
      count_out == $past(count_out) + 16'h1)
    else $error("timer step wrong");
  // With refill set, wrap must load the limit as it stands at the wrap, else zero
  timer_wrap_a: assert property (
    run_reg == 2'h3 && $past(count_out) == 16'hffff |->
      count_out == (ctl_reg[7] ? lim_reg : 16'h0) ##[0:1] wrap_out)
    else $error("timer wrap wrong");
  // Event mode and a full-range refill may wrap on every step
  wrap_once_a: assert property (
    wrap_out && ctl_reg[3:2] != 2'h1 && lim_reg != 16'hffff |=> !wrap_out)
    else $error("wrap pulse too long");
  cover property (wrap_out);
  cover property (run_reg == 2'h3 && count_out == 16'hffff);
  cover property (filter_tick_out && cfg_reg[11:8] == 4'h2);
endmodule
bind timer16_clock_edge_reload timer16_clock_edge_reload_chk u_chk (.clk_in(clk_in),
  .nrst_in(nrst_in), .req_in(req_in), .timer_input_pin_in(timer_input_pin_in),
  .prev_wrap_in(prev_wrap_in), .rdata_out(rdata_out), .count_out(count_out),
  .wrap_out(wrap_out), .filter_tick_out(filter_tick_out));
`default_nettype wire

// ### verilog/tick_divider.sv
`include "timer16_defines.svh"
`default_nettype none

module tick_divider (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [3:0] sel_in,
  output logic tick_out
);

  // ****************************************
  // Free-running prescaler
  // ****************************************

  logic [`DIV_CNT_W-1:0] div_reg; // Phase counter
  logic [`DIV_CNT_W-1:0] div_next; // Next phase
  logic [`DIV_CNT_W-1:0] div_mask; // Low bits that must be zero
  logic tick_next; // One-cycle enable

  assign div_next = div_reg + 7'h01;
  assign div_mask = 7'(({{`DIV_CNT_W{1'b0}}, 1'b1} << sel_in[2:0]) - 8'h01);
  // Top select bit set means reserved: no ticks at all
  assign tick_next = !sel_in[3] && ((div_reg & div_mask) == 7'h00);

  // Counter and registered tick
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      div_reg <= 7'h00;
      tick_out <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_out <= tick_next;
    end
  end

endmodule

`default_nettype wire

// ### verilog/timer16_clock_edge_reload.sv
// Operation
// - Bits 11:8 pick noise filter clock; here it only drives filter_tick_out, pin edges are not filtered
// - Event source: pin or previous timer
// - Event edge field picks counted edges
// - One-shot edge field picks start trigger
// - Measurement edge field picks timed interval
// - Bits 3:0 pick counter clock
// - Timer/one-shot: limit is lower bound
// - Event: limit upper (up), lower (down)
// - New limit applies at next wrap
// - Mode field selects four operating modes
// - Event direction: set up, clear down
// - Refill bit: reload or roll over
//
// Design decision made here: the strobed register port.
`include "timer16_defines.svh"
`default_nettype none

module timer16_clock_edge_reload
  import timer16_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire reg_req_t req_in,
  input wire logic timer_input_pin_in,
  input wire logic prev_wrap_in,
  output logic [31:0] rdata_out,
  output logic [15:0] count_out,
  output logic wrap_out,
  output logic filter_tick_out
);

  // ****************************************
  // Edge decoding helper
  // ****************************************

  // Edge field against seen rise and fall
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                    input logic fall);
    case (sel)
      `EDGE_FALL: edge_hit = fall;
      `EDGE_RISE: edge_hit = rise;
      `EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // ****************************************
  // Register state
  // ****************************************

  logic enable_reg; // Timer running request
  logic [1:0] mode_reg; // Operating mode
  logic direction_reg; // Event count direction
  logic wrap_refill_reg; // Reload on wrap
  logic [3:0] counter_clock_select_reg; // Counter prescaler
  logic [3:0] filter_clock_select_reg; // Filter prescaler
  logic [1:0] edge_sel_reg; // Edge field
  logic event_source_reg; // Event source
  logic [15:0] limit_reg; // Software limit
  logic [15:0] active_limit_reg; // Limit in use
  logic [15:0] count_reg; // Counter
  logic [15:0] measured_reg; // Last measured interval
  logic pin_prev_reg; // Pin one cycle ago
  shot_state_t shot_reg; // One-shot state
  logic wrap_reg; // Wrap pulse
  logic [31:0] rdata_reg; // Read data

  // ****************************************
  // Next values
  // ****************************************

  logic enable_next;
  logic [15:0] active_limit_next;
  logic [15:0] count_next;
  logic [15:0] measured_next;
  shot_state_t shot_next;
  logic [31:0] rdata_next;

  // ****************************************
  // Bus decode
  // ****************************************

  wire logic wr_main = req_in.wr && (req_in.addr == `OFS_MAIN_CONTROL);
  wire logic wr_clock = req_in.wr && (req_in.addr == `OFS_CLOCK_EDGE);
  wire logic wr_limit = req_in.wr && (req_in.addr == `OFS_LIMIT_VALUE);

  // ****************************************
  // Prescaler ticks
  // ****************************************

  logic counter_tick; // Counter advance enable
  logic filter_tick; // Filter advance enable

  tick_divider u_counter_div (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .sel_in(counter_clock_select_reg),
    .tick_out(counter_tick)
  );

  tick_divider u_filter_div (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .sel_in(filter_clock_select_reg),
    .tick_out(filter_tick)
  );

  // ****************************************
  // Input edges and mode decode
  // ****************************************

  wire logic pin_rise = timer_input_pin_in && !pin_prev_reg;
  wire logic pin_fall = !timer_input_pin_in && pin_prev_reg;
  wire logic pin_edge = edge_hit(edge_sel_reg, pin_rise, pin_fall);

  wire logic is_timer = (mode_reg == `MODE_TIMER);
  wire logic is_event = (mode_reg == `MODE_EVENT);
  wire logic is_shot = (mode_reg == `MODE_ONE_SHOT);
  wire logic is_measure = (mode_reg == `MODE_MEASURE);

  wire logic event_hit = event_source_reg ? pin_edge : prev_wrap_in;

  // Direction: only event mode may count down
  wire logic count_up = !is_event || direction_reg;

  // Event up wraps at limit, down wraps at limit
  wire logic [15:0] wrap_point = !count_up ? active_limit_reg :
                                 (is_event ? active_limit_reg : `COUNT_TOP);

  wire logic step = enable_reg && (
                    (is_timer && counter_tick) ||
                    (is_event && event_hit) ||
                    (is_shot && (shot_reg == OS_RUN) && counter_tick));

  wire logic at_wrap = (count_reg == wrap_point);
  wire logic wrap_now = step && at_wrap;

  // Value after wrap; a limit written mid-run lands here
  wire logic [15:0] wrap_value = wrap_refill_reg ? limit_reg :
                                 (count_up ? `COUNT_BOTTOM : `COUNT_TOP);

  // One-shot always refills from the newest limit and then stops
  wire logic [15:0] shot_end_value = limit_reg;

  // Measurement: selected edge closes an interval
  wire logic measure_edge = enable_reg && is_measure && pin_edge;

  // ****************************************
  // One-shot sequencing
  // ****************************************

  always_comb begin
    shot_next = shot_reg;
    case (shot_reg)
      OS_IDLE: begin
        if (enable_reg && is_shot) begin
          shot_next = (edge_sel_reg == `EDGE_NONE) ? OS_RUN : OS_ARMED;
        end
      end
      OS_ARMED: begin
        if (!enable_reg || !is_shot) begin
          shot_next = OS_IDLE;
        end else if (pin_edge) begin
          shot_next = OS_RUN;
        end
      end
      OS_RUN: begin
        if (!enable_reg || !is_shot || wrap_now) begin
          shot_next = OS_IDLE;
        end
      end
      default: begin
        shot_next = OS_IDLE;
      end
    endcase
  end

  // ****************************************
  // Enable bit
  // ****************************************

  // Software write wins over the one-shot end clear
  always_comb begin
    enable_next = enable_reg;
    if (wr_main) begin
      enable_next = req_in.wdata[`POS_ENABLE];
    end else if (is_shot && wrap_now) begin
      enable_next = 1'b0;
    end
  end

  // ****************************************
  // Limit shadow
  // ****************************************

  // Take new limit when stopped, on wrap or on a measurement edge
  always_comb begin
    active_limit_next = active_limit_reg;
    if (!enable_reg || wrap_now || measure_edge) begin
      active_limit_next = limit_reg;
    end
  end

  // ****************************************
  // Counter and measurement
  // ****************************************

  always_comb begin
    count_next = count_reg;
    measured_next = measured_reg;
    if (is_measure) begin
      if (measure_edge) begin
        measured_next = count_reg;
        count_next = `COUNT_BOTTOM;
      end else if (enable_reg && counter_tick && (count_reg != `COUNT_TOP)) begin
        count_next = count_reg + 16'h0001;
      end
    end else if (wrap_now) begin
      count_next = is_shot ? shot_end_value : wrap_value;
    end else if (step) begin
      count_next = count_up ? count_reg + 16'h0001 : count_reg - 16'h0001;
    end
  end

  // ****************************************
  // Read mux
  // ****************************************

  always_comb begin
    rdata_next = 32'h0000_0000;
    if (req_in.rd) begin
      case (req_in.addr)
        `OFS_MAIN_CONTROL: begin
          rdata_next[`POS_ENABLE] = enable_reg;
          rdata_next[`POS_MODE_HI:`POS_MODE_LO] = mode_reg;
          rdata_next[`POS_DIRECTION] = direction_reg;
          rdata_next[`POS_WRAP_REFILL] = wrap_refill_reg;
        end
        `OFS_CLOCK_EDGE: begin
          rdata_next[`POS_COUNTER_CLK_HI:`POS_COUNTER_CLK_LO] = counter_clock_select_reg;
          rdata_next[`POS_EDGE_HI:`POS_EDGE_LO] = edge_sel_reg;
          rdata_next[`POS_EVENT_SOURCE] = event_source_reg;
          rdata_next[`POS_FILTER_CLK_HI:`POS_FILTER_CLK_LO] = filter_clock_select_reg;
        end
        `OFS_LIMIT_VALUE: begin
          rdata_next[15:0] = limit_reg;
        end
        `OFS_COUNT: begin
          rdata_next[15:0] = count_reg;
        end
        `OFS_MEASURED: begin
          rdata_next[15:0] = measured_reg;
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************
  // Control registers
  // ****************************************

  // Main control fields
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      mode_reg <= `RST_MODE;
      direction_reg <= 1'b0;
      wrap_refill_reg <= 1'b0;
    end else if (wr_main) begin
      mode_reg <= req_in.wdata[`POS_MODE_HI:`POS_MODE_LO];
      direction_reg <= req_in.wdata[`POS_DIRECTION];
      wrap_refill_reg <= req_in.wdata[`POS_WRAP_REFILL];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      counter_clock_select_reg <= `RST_CLK_SEL;
      filter_clock_select_reg <= `RST_CLK_SEL;
      edge_sel_reg <= `RST_EDGE;
      event_source_reg <= 1'b0;
    end else if (wr_clock) begin
      counter_clock_select_reg <= req_in.wdata[`POS_COUNTER_CLK_HI:`POS_COUNTER_CLK_LO];
      filter_clock_select_reg <= req_in.wdata[`POS_FILTER_CLK_HI:`POS_FILTER_CLK_LO];
      edge_sel_reg <= req_in.wdata[`POS_EDGE_HI:`POS_EDGE_LO];
      event_source_reg <= req_in.wdata[`POS_EVENT_SOURCE];
    end
  end

  // Limit stored as written, zero not checked
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      limit_reg <= `RST_LIMIT;
    end else if (wr_limit) begin
      limit_reg <= req_in.wdata[15:0];
    end
  end

  // ****************************************
  // Timer state
  // ****************************************

  // Counter, shadow, sequencer
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      enable_reg <= 1'b0;
      active_limit_reg <= `RST_LIMIT;
      count_reg <= `RST_COUNT;
      measured_reg <= 16'h0000;
      shot_reg <= OS_IDLE;
      pin_prev_reg <= 1'b0;
    end else begin
      enable_reg <= enable_next;
      active_limit_reg <= active_limit_next;
      count_reg <= count_next;
      measured_reg <= measured_next;
      shot_reg <= shot_next;
      pin_prev_reg <= timer_input_pin_in;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************

  // Registered outputs
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      rdata_reg <= 32'h0000_0000;
      wrap_reg <= 1'b0;
      filter_tick_out <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      wrap_reg <= wrap_now;
      filter_tick_out <= filter_tick;
    end
  end

  assign rdata_out = rdata_reg;
  assign count_out = count_reg;
  assign wrap_out = wrap_reg;

endmodule

`default_nettype wire

// ### verilog/timer16_defines.svh
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

// Register byte offsets
`define OFS_MAIN_CONTROL 8'h00
`define OFS_CLOCK_EDGE 8'h04
`define OFS_LIMIT_VALUE 8'h08
`define OFS_COUNT 8'h0c
`define OFS_MEASURED 8'h10

// Main control field positions
`define POS_ENABLE 0
`define POS_MODE_LO 2
`define POS_MODE_HI 3
`define POS_DIRECTION 4
`define POS_WRAP_REFILL 7

// Clock and edge control field positions
`define POS_COUNTER_CLK_LO 0
`define POS_COUNTER_CLK_HI 3
`define POS_EDGE_LO 5
`define POS_EDGE_HI 6
`define POS_EVENT_SOURCE 7
`define POS_FILTER_CLK_LO 8
`define POS_FILTER_CLK_HI 11

// Mode encodings
`define MODE_TIMER 2'h0
`define MODE_EVENT 2'h1
`define MODE_ONE_SHOT 2'h2
`define MODE_MEASURE 2'h3

// Edge field encodings
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h2
`define EDGE_NONE 2'h3

// Reset values
`define RST_LIMIT 16'hffff
`define RST_COUNT 16'hffff
`define RST_CLK_SEL 4'h0
`define RST_EDGE 2'h0
`define RST_MODE 2'h0

// Counter wrap points
`define COUNT_TOP 16'hffff
`define COUNT_BOTTOM 16'h0000

// Prescaler: selects 0..7 divide by 2^sel, 1xxx stop
`define DIV_CNT_W 7

`endif

// ### verilog/timer16_pkg.sv
`default_nettype none

package timer16_pkg;

  // Register port request bundle
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // One-shot sequencing states
  typedef enum logic [1:0] {
    OS_IDLE,
    OS_ARMED,
    OS_RUN
  } shot_state_t;

endpackage

`default_nettype wire
